// ===== hw/adcs_pkg.sv
// package: register map, field positions, reset values and cycle counts of the converter sequencer
package adcs_pkg;

  localparam int ADDR_W = 4;

  // register offsets
  localparam logic [3:0] OFF_CTRL0 = 4'h0;
  localparam logic [3:0] OFF_CTRL1 = 4'h1;
  localparam logic [3:0] OFF_CTRL2 = 4'h2;
  localparam logic [3:0] OFF_STAT = 4'h3;
  localparam logic [3:0] OFF_MASK = 4'h4;
  localparam logic [3:0] OFF_RES0 = 4'h8;

  // field positions
  localparam int CTRL0_CHAN_LSB = 0;
  localparam int CTRL0_MODE_LSB = 3;
  localparam int CTRL0_START_BIT = 6;
  localparam int CTRL1_SWEEP_LSB = 0;
  localparam int CTRL1_CLK_LSB = 3;
  localparam int CTRL1_VREF_BIT = 5;
  localparam int CTRL2_SH_BIT = 0;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 7;

  // reset values and writable bits
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] RES_RST = 8'h00;
  localparam logic [7:0] CTRL2_USED = 8'h01;
  localparam logic [7:0] STAT_USED = 8'h01;

  // operating modes
  localparam logic [2:0] MODE_ONESHOT = 3'h0;
  localparam logic [2:0] MODE_REPEAT = 3'h1;
  localparam logic [2:0] MODE_SSWEEP = 3'h2;
  localparam logic [2:0] MODE_RSWEEP0 = 3'h3;
  localparam logic [2:0] MODE_RSWEEP1 = 3'h4;

  // conversion clock select and divider terminal counts
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV1 = 2'h2;
  localparam logic [1:0] DIV4_LIM = 2'h3;
  localparam logic [1:0] DIV2_LIM = 2'h1;
  localparam logic [1:0] DIV1_LIM = 2'h0;

  // conversion clock cycles per channel
  localparam logic [5:0] CONV_CYC_PLAIN = 6'h31;
  localparam logic [5:0] CONV_CYC_SH = 6'h1C;

  typedef enum logic {ADCS_IDLE, ADCS_CONV} adcs_state_e;

endpackage : adcs_pkg

// ===== hw/adcs_div_if.sv
// interface: conversion clock select and conversion clock enable pulse
`timescale 1ns/1ns
interface adcs_div_if;
  logic [1:0] sel;
  logic tick;
  modport div (input sel, output tick);
  modport user (output sel, input tick);
endinterface : adcs_div_if

// ===== hw/adcs_div.sv
// module: conversion clock enable divider, undivided, by two or by four
`timescale 1ns/1ns
module adcs_div (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // divider select and enable
  adcs_div_if.div div_bus
);
  import adcs_pkg::*;

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [1:0] lim;

  always_comb begin
    case (div_bus.sel)
      CLK_DIV4: lim = DIV4_LIM;
      CLK_DIV2: lim = DIV2_LIM;
      default: lim = DIV1_LIM;
    endcase
    tick_next = (cnt_reg >= lim);
    cnt_next = tick_next ? 2'h0 : cnt_reg + 2'h1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= 2'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign div_bus.tick = tick_reg;

  a_tick_div4: assert property (@(posedge i_clk) disable iff (i_rst)
    (div_bus.tick && div_bus.sel == CLK_DIV4) ##1 (div_bus.sel == CLK_DIV4 && !div_bus.tick)[*3] |-> ##1 div_bus.tick)
    else $error("divide-by-4 enable not every fourth cycle");
  a_tick_div2: assert property (@(posedge i_clk) disable iff (i_rst)
    (div_bus.tick && div_bus.sel == CLK_DIV2) ##1 (div_bus.sel == CLK_DIV2) |-> !div_bus.tick ##1 div_bus.tick)
    else $error("divide-by-2 enable not every second cycle");

endmodule : adcs_div

// ===== hw/adcs_top.sv
// module: sequencing and register control of the eight-bit successive approximation converter
// Operation
// - ladder connect bit drives reference switch
// - eight-bit result lands in channel's register
// - conversion clock undivided, halved or quartered
// - five operating modes selectable
// - six analog channels on shared port pins
// - start flag rising edge starts conversion
// - 49 cycles plain, 28 with hold
// - one-shot converts once, interrupts at end
// - repeat converts continuously, no interrupt
// - single sweep of 2/4/6 channels, interrupt
// - repeat sweep 0 loops group, no interrupt
// - repeat sweep 1 interleaves emphasised channels
// - sample-and-hold bit fixed before start
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
module adcs_top #(
  parameter int NUM_CH = 6
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [adcs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // converter core
  input wire logic [7:0] i_conv_data,
  output logic o_conv_start,
  output logic [2:0] o_chan,
  output logic o_conv_tick,
  output logic o_sh_en,
  output logic o_ladder_connect,
  output logic o_busy,
  // interrupt
  output logic o_irq
);
  import adcs_pkg::*;

  if (NUM_CH < 6 || NUM_CH > 8) begin : g_bad_ch
    $error("channel count must be 6 to 8");
  end

  localparam logic [2:0] LAST_CH = 3'(NUM_CH - 1);

  function automatic logic [2:0] sweep_last(input logic [1:0] sel);
    case (sel)
      2'h0: sweep_last = 3'h1;
      2'h1: sweep_last = 3'h3;
      default: sweep_last = 3'h5;
    endcase
  endfunction : sweep_last

  adcs_div_if div_bus ();

  logic [7:0] ctrl0_reg, ctrl0_next;
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] res_reg [NUM_CH];
  logic [7:0] res_next [NUM_CH];
  adcs_state_e state_reg, state_next;
  logic [2:0] mode_reg, mode_next;
  logic [2:0] chan_reg, chan_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [1:0] sel_reg, sel_next;
  logic sh_reg, sh_next;
  logic phase_reg, phase_next;
  logic emph_reg, emph_next;
  logic two_emph_reg, two_emph_next;
  logic [2:0] other_reg, other_next;
  logic start_pls_reg, start_pls_next;
  logic busy_reg, busy_next;
  logic irq_reg, irq_next;
  logic [7:0] stat_set;
  logic [7:0] stat_clr;
  logic [5:0] lim_m1;
  logic [2:0] first_ch;
  logic [2:0] emph_cnt;
  logic finish;
  logic go;
  logic stop;
  logic done;

  assign div_bus.sel = ctrl1_reg[CTRL1_CLK_LSB +: 2];

  adcs_div u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .div_bus(div_bus)
  );

  assign go = i_wr && i_addr == OFF_CTRL0 && i_wdata[CTRL0_START_BIT] && !ctrl0_reg[CTRL0_START_BIT];
  assign stop = i_wr && i_addr == OFF_CTRL0 && !i_wdata[CTRL0_START_BIT];
  assign lim_m1 = (sh_reg ? CONV_CYC_SH : CONV_CYC_PLAIN) - 6'h01;
  assign done = state_reg == ADCS_CONV && !stop && div_bus.tick && cnt_reg == lim_m1;
  assign emph_cnt = two_emph_reg ? 3'h2 : 3'h1;

  // per-channel result registers
  for (genvar g = 0; g < NUM_CH; g++) begin : g_res
    assign res_next[g] = (done && chan_reg == 3'(g)) ? i_conv_data : res_reg[g];
  end

  always_comb begin
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    mask_next = mask_reg;
    stat_set = 8'h00;
    stat_clr = 8'h00;
    state_next = state_reg;
    mode_next = mode_reg;
    chan_next = chan_reg;
    cnt_next = cnt_reg;
    sel_next = sel_reg;
    sh_next = sh_reg;
    phase_next = phase_reg;
    emph_next = emph_reg;
    two_emph_next = two_emph_reg;
    other_next = other_reg;
    start_pls_next = 1'b0;
    finish = 1'b0;
    first_ch = i_wdata[CTRL0_CHAN_LSB +: 3];
    if (first_ch > LAST_CH) begin
      first_ch = LAST_CH;
    end
    if (i_wr) begin
      case (i_addr)
        OFF_CTRL0: ctrl0_next = i_wdata;
        OFF_CTRL1: ctrl1_next = i_wdata;
        OFF_CTRL2: ctrl2_next = i_wdata & CTRL2_USED;
        OFF_STAT: stat_clr = i_wdata & STAT_USED;
        OFF_MASK: mask_next = i_wdata & STAT_USED;
        default: ;
      endcase
    end
    case (state_reg)
      ADCS_IDLE: begin
        if (go) begin
          state_next = ADCS_CONV;
          mode_next = i_wdata[CTRL0_MODE_LSB +: 3];
          sel_next = ctrl1_reg[CTRL1_SWEEP_LSB +: 2];
          two_emph_next = ctrl1_reg[CTRL1_SWEEP_LSB];
          sh_next = ctrl2_reg[CTRL2_SH_BIT];
          cnt_next = 6'h00;
          start_pls_next = 1'b1;
          phase_next = 1'b0;
          emph_next = 1'b0;
          other_next = ctrl1_reg[CTRL1_SWEEP_LSB] ? 3'h2 : 3'h1;
          if (i_wdata[CTRL0_MODE_LSB +: 3] == MODE_ONESHOT || i_wdata[CTRL0_MODE_LSB +: 3] == MODE_REPEAT) begin
            chan_next = first_ch;
          end else begin
            chan_next = 3'h0;
          end
        end
      end
      ADCS_CONV: begin
        if (stop) begin
          state_next = ADCS_IDLE;
        end else if (div_bus.tick) begin
          if (cnt_reg != lim_m1) begin
            cnt_next = cnt_reg + 6'h01;
          end else begin
            cnt_next = 6'h00;
            start_pls_next = 1'b1;
            case (mode_reg)
              MODE_ONESHOT: finish = 1'b1;
              MODE_REPEAT: chan_next = chan_reg;
              MODE_SSWEEP: begin
                if (chan_reg == sweep_last(sel_reg)) begin
                  finish = 1'b1;
                end else begin
                  chan_next = chan_reg + 3'h1;
                end
              end
              MODE_RSWEEP0: begin
                chan_next = (chan_reg == sweep_last(sel_reg)) ? 3'h0 : chan_reg + 3'h1;
              end
              MODE_RSWEEP1: begin
                if (!phase_reg) begin
                  chan_next = other_reg;
                  phase_next = 1'b1;
                end else begin
                  emph_next = two_emph_reg ? !emph_reg : 1'b0;
                  chan_next = {2'b00, emph_next};
                  other_next = (other_reg == LAST_CH) ? emph_cnt : other_reg + 3'h1;
                  phase_next = 1'b0;
                end
              end
              default: finish = 1'b1;
            endcase
            if (finish) begin
              state_next = ADCS_IDLE;
              start_pls_next = 1'b0;
              ctrl0_next[CTRL0_START_BIT] = 1'b0;
              stat_set[STAT_DONE_BIT] = 1'b1;
            end
          end
        end
      end
      default: state_next = ADCS_IDLE;
    endcase
    stat_next = (stat_reg & ~stat_clr) | stat_set;
    busy_next = state_next == ADCS_CONV;
    irq_next = |(stat_next & mask_next);
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        OFF_CTRL0: rdata_next = ctrl0_reg;
        OFF_CTRL1: rdata_next = ctrl1_reg;
        OFF_CTRL2: rdata_next = ctrl2_reg;
        OFF_STAT: rdata_next = stat_reg | {busy_reg, 7'h00};
        OFF_MASK: rdata_next = mask_reg;
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (i_addr == OFF_RES0 + 4'(i)) begin
              rdata_next = res_reg[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl0_reg <= CTRL0_RST;
      ctrl1_reg <= CTRL1_RST;
      ctrl2_reg <= CTRL2_RST;
      stat_reg <= STAT_RST;
      mask_reg <= MASK_RST;
      rdata_reg <= 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
        res_reg[i] <= RES_RST;
      end
      state_reg <= ADCS_IDLE;
      mode_reg <= MODE_ONESHOT;
      chan_reg <= 3'h0;
      cnt_reg <= 6'h00;
      sel_reg <= 2'h0;
      sh_reg <= 1'b0;
      phase_reg <= 1'b0;
      emph_reg <= 1'b0;
      two_emph_reg <= 1'b0;
      other_reg <= 3'h1;
      start_pls_reg <= 1'b0;
      busy_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      for (int i = 0; i < NUM_CH; i++) begin
        res_reg[i] <= res_next[i];
      end
      state_reg <= state_next;
      mode_reg <= mode_next;
      chan_reg <= chan_next;
      cnt_reg <= cnt_next;
      sel_reg <= sel_next;
      sh_reg <= sh_next;
      phase_reg <= phase_next;
      emph_reg <= emph_next;
      two_emph_reg <= two_emph_next;
      other_reg <= other_next;
      start_pls_reg <= start_pls_next;
      busy_reg <= busy_next;
      irq_reg <= irq_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_conv_start = start_pls_reg;
  assign o_chan = chan_reg;
  assign o_conv_tick = div_bus.tick;
  assign o_sh_en = sh_reg;
  assign o_ladder_connect = ctrl1_reg[CTRL1_VREF_BIT];
  assign o_busy = busy_reg;
  assign o_irq = irq_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_ladder_follow: assert property (
    (i_wr && i_addr == OFF_CTRL1) |=> (o_ladder_connect == $past(i_wdata[CTRL1_VREF_BIT])))
    else $error("ladder connect does not follow written bit");
  a_result_store: assert property (
    done |=> (res_reg[$past(chan_reg)] == $past(i_conv_data)))
    else $error("result not stored in converted channel register");
  a_start_go: assert property (
    (go && !o_busy) |=> (o_busy && o_conv_start && cnt_reg == 6'h00))
    else $error("start flag rise did not begin a conversion");
  a_sh_length: assert property (
    (o_conv_start && o_sh_en && mode_reg == MODE_REPEAT && div_bus.sel == CLK_DIV2 && !o_conv_tick)
      ##1 (!stop && div_bus.sel == CLK_DIV2)[*8] |-> ##48 (o_conv_start || !o_busy))
    else $error("sample-and-hold conversion not 28 cycles");
  a_oneshot_end: assert property (
    (done && mode_reg == MODE_ONESHOT) |=> (!o_busy && stat_reg[STAT_DONE_BIT]))
    else $error("one-shot end did not stop and flag");
  a_repeat_quiet: assert property (
    (o_busy && mode_reg == MODE_REPEAT && !stat_reg[STAT_DONE_BIT] && !(i_wr && i_addr == OFF_STAT))
      |=> !stat_reg[STAT_DONE_BIT])
    else $error("repeat mode raised the done flag");
  a_sweep_step: assert property (
    (done && mode_reg == MODE_SSWEEP && chan_reg != sweep_last(sel_reg)) |=> (chan_reg == $past(chan_reg) + 3'h1 && o_conv_start))
    else $error("single sweep did not step to next channel");
  a_rsweep0_wrap: assert property (
    (done && mode_reg == MODE_RSWEEP0 && chan_reg == sweep_last(sel_reg)) |=> (chan_reg == 3'h0 && o_busy))
    else $error("repeat sweep 0 did not wrap to first channel");
  a_emph_return: assert property (
    (done && mode_reg == MODE_RSWEEP1 && phase_reg) |=> (chan_reg < emph_cnt && !phase_reg))
    else $error("repeat sweep 1 did not return to emphasised channel");
  a_sh_held: assert property (
    (o_busy && $past(o_busy)) |-> $stable(o_sh_en))
    else $error("sample-and-hold changed during conversion");
  a_start_clear: assert property (
    (done && mode_reg == MODE_SSWEEP && chan_reg == sweep_last(sel_reg)) |=> !ctrl0_reg[CTRL0_START_BIT])
    else $error("start flag not cleared at sweep end");

  c_oneshot_done: cover property (done && mode_reg == MODE_ONESHOT);
  c_sweep_six: cover property (done && mode_reg == MODE_SSWEEP && chan_reg == 3'h5);
  c_emph_two: cover property (done && mode_reg == MODE_RSWEEP1 && phase_reg && two_emph_reg);
  c_abort: cover property (stop && o_busy);

endmodule : adcs_top

// ===== sim/adcs_core_model.sv
// converter core model: result valid from the deciding tick, a moving pattern otherwise
`timescale 1ns/1ns
module adcs_core_model (
  // clock
  input wire logic i_clk,
  // sequencer side
  input wire logic i_conv_start,
  input wire logic [2:0] i_chan,
  input wire logic i_conv_tick,
  input wire logic i_sh_en,
  // result
  output logic [7:0] o_conv_data
);
  int cnt = 0;
  logic [2:0] chan_reg = 3'h0;
  logic [7:0] noise_reg = 8'h00;
  // ticks counted from the start cycle, hold shortens the count
  always @(posedge i_clk) begin
    noise_reg <= noise_reg + 8'h3B;
    if (i_conv_start) begin
      chan_reg <= i_chan;
      cnt <= i_conv_tick ? 1 : 0;
    end else if (i_conv_tick) begin
      cnt <= cnt + 1;
    end
  end
  // eight-bit value tied to the channel, so a misfiled result shows; channel pins only ever read
  always_comb begin
    if (!i_conv_start && cnt >= (i_sh_en ? 28 : 49) - 1) o_conv_data = 8'h5A ^ {chan_reg, chan_reg, 2'b01};
    else o_conv_data = noise_reg;
  end
endmodule : adcs_core_model

// ===== sim/testbench.sv
// testbench: register port master, converter core model and sequencing scenarios
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import adcs_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata, i_conv_data;
  logic o_conv_start, o_conv_tick, o_sh_en, o_ladder_connect, o_busy, o_irq;
  logic [2:0] o_chan;
  int mismatches = 0;
  int n_tests = 0;
  int nticks = 0;
  logic [2:0] chans[$];
  adcs_top #(.NUM_CH(6)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_data(i_conv_data), .o_conv_start(o_conv_start), .o_chan(o_chan),
    .o_conv_tick(o_conv_tick), .o_sh_en(o_sh_en), .o_ladder_connect(o_ladder_connect), .o_busy(o_busy),
    .o_irq(o_irq));
  adcs_core_model core (.i_clk(i_clk), .i_conv_start(o_conv_start), .i_chan(o_chan), .i_conv_tick(o_conv_tick),
    .i_sh_en(o_sh_en), .o_conv_data(i_conv_data));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  // channel order and busy ticks seen at the core side
  always @(posedge i_clk) begin
    if (o_conv_start === 1'b1) chans.push_back(o_chan);
    if (o_busy === 1'b1 && o_conv_tick === 1'b1) nticks++;
  end
  function automatic logic [7:0] val(input logic [2:0] c);
    return 8'h5A ^ {c, c, 2'b01};
  endfunction : val
  function automatic logic [7:0] c1(input logic [1:0] sw);
    return {2'b00, 1'b1, CLK_DIV2, 1'b0, sw};
  endfunction : c1
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask : rchk
  task automatic start(input logic [2:0] mode, input logic [2:0] ch);
    wr(OFF_CTRL0, {2'b01, mode, ch});
  endtask : start
  task automatic wait_idle(input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge i_clk);
      #1;
      if (o_busy === 1'b0) return;
    end
    mismatches++;
    finish_test();
  endtask : wait_idle
  task automatic t_reset();
    `CHK(o_busy, 1'b0)
    `CHK(o_ladder_connect, 1'b0)
    rchk(OFF_CTRL0, CTRL0_RST);
    rchk(OFF_CTRL1, CTRL1_RST);
    rchk(OFF_STAT, STAT_RST);
    rchk(OFF_MASK, MASK_RST);
    rchk(OFF_RES0, RES_RST);
    rchk(4'hF, 8'h00);
    wr(OFF_CTRL2, 8'hFF);
    rchk(OFF_CTRL2, CTRL2_USED);
    wr(OFF_CTRL2, 8'h00);
    rchk(OFF_CTRL2, CTRL2_RST);
  endtask : t_reset
  // select values follow the loop index: quarter, half, undivided
  task automatic t_clock();
    int i, k;
    for (i = 0; i < 3; i++) begin
      wr(OFF_CTRL1, {2'b00, 1'b1, 2'(i), 3'h0});
      for (k = 0; k < 9; k++) begin
        @(posedge i_clk);
        #1;
        if (o_conv_tick === 1'b1) break;
      end
      for (k = 1; k < 9; k++) begin
        @(posedge i_clk);
        #1;
        if (o_conv_tick === 1'b1) break;
      end
      `CHK(k, 4 >> i)
      `CHK(o_ladder_connect, 1'b1)
    end
    wr(OFF_CTRL1, 8'h00);
    @(posedge i_clk);
    #1;
    `CHK(o_ladder_connect, 1'b0)
    wr(OFF_CTRL1, c1(2'h0));
  endtask : t_clock
  // hold flipped mid-run must not change the tick count
  task automatic t_oneshot(input logic sh, input logic [2:0] ch, input logic m);
    wr(OFF_MASK, {7'h0, m});
    wr(OFF_CTRL2, {7'h0, sh});
    nticks = 0;
    chans = {};
    start(MODE_ONESHOT, ch);
    wr(OFF_CTRL2, {7'h0, ~sh});
    #1;
    `CHK(o_sh_en, sh)
    wait_idle(500);
    `CHK(nticks, sh ? 28 : 49)
    `CHK(chans.size(), 1)
    `CHK(chans[0], ch)
    rchk(4'(OFF_RES0 + ch), val(ch));
    rchk(OFF_CTRL0, {2'b00, MODE_ONESHOT, ch});
    rchk(OFF_STAT, 8'h01);
    `CHK(o_irq, m)
    wr(OFF_MASK, 8'h01);
    @(posedge i_clk);
    #1;
    `CHK(o_irq, 1'b1)
    wr(OFF_STAT, 8'h01);
    @(posedge i_clk);
    #1;
    `CHK(o_irq, 1'b0)
  endtask : t_oneshot
  task automatic t_sweep(input logic [1:0] g);
    int i, n;
    wr(OFF_CTRL1, c1(g));
    wr(OFF_CTRL2, 8'h01);
    chans = {};
    start(MODE_SSWEEP, 3'h0);
    wait_idle(2000);
    n = (g == 2'h0) ? 2 : (g == 2'h1) ? 4 : 6;
    `CHK(chans.size(), n)
    for (i = 0; i < n; i++) begin
      `CHK(chans[i], 3'(i))
      rchk(4'(OFF_RES0 + i), val(3'(i)));
    end
    rchk(OFF_CTRL0, {2'b00, MODE_SSWEEP, 3'h0});
    rchk(OFF_STAT, 8'h01);
    `CHK(o_irq, 1'b1)
    wr(OFF_STAT, 8'h01);
  endtask : t_sweep
  // endless modes: check order, then abort by writing zero to the start flag
  task automatic t_loop(input logic [2:0] mode, input logic [2:0] ch, input logic [1:0] sw, input logic [2:0] exp[$]);
    int i;
    wr(OFF_CTRL1, c1(sw));
    chans = {};
    start(mode, ch);
    for (i = 0; i < 5000 && chans.size() <= exp.size(); i++) @(posedge i_clk);
    if (chans.size() <= exp.size()) begin
      mismatches++;
      finish_test();
    end
    wr(OFF_CTRL0, {2'b00, mode, ch});
    @(posedge i_clk);
    #1;
    `CHK(o_busy, 1'b0)
    for (i = 0; i < exp.size(); i++) `CHK(chans[i], exp[i])
    rchk(OFF_STAT, 8'h00);
    `CHK(o_irq, 1'b0)
  endtask : t_loop
  // reset while converting: sequencer must come back idle with registers cleared
  task automatic t_midreset();
    start(MODE_REPEAT, 3'h1);
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    `CHK(o_busy, 1'b0)
    `CHK(o_ladder_connect, 1'b0)
    rchk(OFF_CTRL0, CTRL0_RST);
    rchk(OFF_STAT, STAT_RST);
  endtask : t_midreset
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_clock();
    t_oneshot(1'b1, 3'h3, 1'b1);
    t_oneshot(1'b0, 3'h5, 1'b0);
    t_sweep(2'h0);
    t_sweep(2'h1);
    t_sweep(2'h2);
    t_loop(MODE_REPEAT, 3'h2, 2'h0, {3'h2, 3'h2, 3'h2});
    t_loop(MODE_RSWEEP0, 3'h0, 2'h0, {3'h0, 3'h1, 3'h0, 3'h1});
    t_loop(MODE_RSWEEP1, 3'h0, 2'h0, {3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h3, 3'h0, 3'h4, 3'h0, 3'h5, 3'h0, 3'h1});
    t_loop(MODE_RSWEEP1, 3'h0, 2'h1, {3'h0, 3'h2, 3'h1, 3'h3, 3'h0, 3'h4, 3'h1, 3'h5, 3'h0, 3'h2});
    t_midreset();
    finish_test();
  end
endmodule : testbench
